/* sram_pkg.sv */
// Purpose: shared constants, types and helpers for the burst SRAM cycle decode
// Assumes: 36-bit word in four 9-bit lanes, parity in each lane's top bit
// Notes: array depth is a small model of the storage
package sram_pkg;
   localparam int DATA_W = 36;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int ADDR_W = 19;
   localparam int IDX_W = 4;
   localparam int MEM_WORDS = 16;
   localparam int BURST_W = 2;
   localparam int BUF_DEPTH = 2;
   localparam int ENTRY_W = IDX_W + LANES + DATA_W;
   localparam int AV_ADDR_W = 5;
   localparam int AV_DATA_W = 32;
   localparam int HI_W = DATA_W - AV_DATA_W;

   // register byte offsets
   localparam logic [AV_ADDR_W-1:0] REG_CTRL = 5'h00;
   localparam logic [AV_ADDR_W-1:0] REG_STATUS = 5'h04;
   localparam logic [AV_ADDR_W-1:0] REG_MEM_ADDR = 5'h08;
   localparam logic [AV_ADDR_W-1:0] REG_MEM_DLO = 5'h0C;
   localparam logic [AV_ADDR_W-1:0] REG_MEM_DHI = 5'h10;

   // control fields
   localparam int CTRL_W = 2;
   localparam int CTRL_SLEEP_BIT = 0;
   localparam int CTRL_HOLD_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RST = 2'h0;

   // status fields
   localparam int ST_CYC_LSB = 0;
   localparam int ST_BURST_LSB = 3;
   localparam int ST_SLEEP_BIT = 5;
   localparam int ST_FULL_BIT = 6;

   typedef enum logic [2:0] {
      CYC_IDLE = 3'b000,
      CYC_DESEL = 3'b001,
      CYC_READ = 3'b010,
      CYC_WRITE = 3'b011,
      CYC_SLEEP = 3'b100
   } cyc_t;

   // burst address from seed and count
   function automatic logic [BURST_W-1:0] burst_addr(input logic [BURST_W-1:0] seed,
                                                     input logic [BURST_W-1:0] cnt,
                                                     input logic linear);
      burst_addr = linear ? BURST_W'(seed + cnt) : (seed ^ cnt);
   endfunction : burst_addr

   // replace selected lanes of a word
   function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] base,
                                                    input logic [DATA_W-1:0] data,
                                                    input logic [LANES-1:0] lanes);
      lane_merge = base;
      for (int k = 0; k < LANES; k++) begin
         if (lanes[k]) begin
            lane_merge[k*LANE_W +: LANE_W] = data[k*LANE_W +: LANE_W];
         end
      end
   endfunction : lane_merge
endpackage : sram_pkg

/* pair_buffer.sv */
// Purpose: small shift fifo between write capture and the storage array
// Assumes: in_ready low means a pushed word is refused
// Notes: every entry is visible for read forwarding
`timescale 1ns/1ps
module pair_buffer #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // entry view
   output logic [W-1:0] ent_data [DEPTH],
   output logic [DEPTH-1:0] ent_valid
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [CW-1:0] count_ff;
   logic [W-1:0] data_ff [DEPTH];
   logic push;
   logic pop;
   logic [CW-1:0] wr_idx;

   assign in_ready = (count_ff != CW'(DEPTH));
   assign out_valid = (count_ff != '0);
   assign out_data = data_ff[0];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign wr_idx = count_ff - CW'(pop);

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         ent_data[i] = data_ff[i];
         ent_valid[i] = (CW'(i) < count_ff);
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         count_ff <= '0;
      end else begin
         count_ff <= count_ff + CW'(push) - CW'(pop);
      end
   end

   // shift toward head on pop
   always_ff @(posedge mclk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (push && (CW'(i) == wr_idx)) begin
            data_ff[i] <= in_data;
         end else if (pop && (i < DEPTH - 1)) begin
            data_ff[i] <= data_ff[(i < DEPTH - 1) ? i + 1 : i];
         end
      end
   end
endmodule : pair_buffer

/* sram_cycle_decode.sv */
// Purpose: cycle decode, burst counter, byte write and data bus control
// Assumes: synchronous pins are timed to mclk; sleep and output enable are async
// Notes: registers over Avalon-MM; pending writes are forwarded to pin reads, not to register reads
// Function
// - selects inactive with controller strobe low, or processor strobe low and chip_sel_low_a low: deselect cycle, data bus tri-stated
// - sleep request high: sleep, data pins tri-stated whatever else happens
// - selected with processor strobe low: read burst at external address
// - selected, controller strobe low, processor high: burst start, write per strobe
// - controller strobe high, advance low: next burst address, read or write
// - controller strobe high, advance high: repeat current address
// - write strobe active on global write, or gate plus any lane low
// - all write inputs high means read
// - processor-strobe start is always a read, write inputs ignored
// - writes only after processor start or with controller start
// - output enable masked internally during write cycles
// - data drivers follow cycle type and asynchronous output enable
// - read drives data only with output enable low and no sleep; burst continuation reads drive even with chip_sel_low_a high
// - any lane combination writes those lanes with parity, others kept
// - two-bit wraparound burst counter seeded from low address bits
// - linear order when mode_linear high, else interleaved xor order
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module sram_cycle_decode
   import sram_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // synchronous memory pins
   input wire logic [sram_pkg::ADDR_W-1:0] addr,
   input wire logic chip_sel_low_a,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_b,
   input wire logic processor_strobe,
   input wire logic controller_strobe,
   input wire logic burst_advance_n,
   input wire logic global_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [sram_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic [sram_pkg::DATA_W-1:0] dq_in,
   // asynchronous and static pins
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic mode_linear,
   // data drive
   output logic [sram_pkg::DATA_W-1:0] dq_out,
   output logic dq_oe,
   output logic wr_accept,
   // avalon-mm slave
   input wire logic [sram_pkg::AV_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [sram_pkg::AV_DATA_W-1:0] avs_writedata,
   output logic [sram_pkg::AV_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest
);
   import sram_pkg::*;

   localparam int HIGH_W = IDX_W - BURST_W;

   // synchronisers
   logic sleep_meta_ff;
   logic sleep_sync_ff;
   logic mode_meta_ff;
   logic mode_ff;

   // cycle and burst state
   cyc_t cyc_ff;
   cyc_t nxt_cyc;
   logic burst_open_ff;
   logic [BURST_W-1:0] seed_ff;
   logic [BURST_W-1:0] cnt_ff;
   logic [HIGH_W-1:0] high_ff;
   logic rd_drive_ff;
   logic [DATA_W-1:0] dq_out_ff;

   // decode results
   logic sel;
   logic sleep_now;
   logic wr_strobe;
   logic do_begin;
   logic do_adv;
   logic do_access;
   logic do_write;
   logic [LANES-1:0] lanes;
   logic [IDX_W-1:0] acc_idx;
   logic [DATA_W-1:0] fwd_word;

   // registers
   logic [CTRL_W-1:0] ctrl_ff;
   logic [IDX_W-1:0] mem_addr_ff;
   logic [HI_W-1:0] dhi_ff;
   logic ack_ff;
   logic [AV_DATA_W-1:0] rdata_ff;
   logic av_req;
   logic av_acc;
   logic sw_mem_wr;

   // storage and buffer
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic buf_in_ready;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [ENTRY_W-1:0] buf_out_data;
   logic [ENTRY_W-1:0] ent_data [BUF_DEPTH];
   logic [BUF_DEPTH-1:0] ent_valid;
   logic [IDX_W-1:0] drain_idx;
   logic [LANES-1:0] drain_lanes;
   logic [DATA_W-1:0] drain_data;

   // two-flop synchronisers for the sleep and mode pins; output enable is not synchronised
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         sleep_meta_ff <= 1'b0;
         sleep_sync_ff <= 1'b0;
         mode_meta_ff <= 1'b0;
         mode_ff <= 1'b0;
      end else begin
         sleep_meta_ff <= sleep_request;
         sleep_sync_ff <= sleep_meta_ff;
         mode_meta_ff <= mode_linear;
         mode_ff <= mode_meta_ff;
      end
   end

   assign sleep_now = sleep_sync_ff || ctrl_ff[CTRL_SLEEP_BIT];
   assign sel = !chip_sel_low_a && chip_sel_high && !chip_sel_low_b;
   assign wr_strobe = !global_write_n || (!byte_write_gate_n && !(&byte_lane_write_n));

   // lane selection
   always_comb begin
      if (!global_write_n) begin
         lanes = '1;
      end else if (!byte_write_gate_n) begin
         lanes = ~byte_lane_write_n;
      end else begin
         lanes = '0;
      end
   end

   // cycle decode at each clock rise
   always_comb begin
      nxt_cyc = CYC_IDLE;
      do_begin = 1'b0;
      do_adv = 1'b0;
      do_access = 1'b0;
      do_write = 1'b0;
      if (sleep_now) begin
         nxt_cyc = CYC_SLEEP;
      end else if (sel && !processor_strobe) begin
         nxt_cyc = CYC_READ;
         do_begin = 1'b1;
         do_access = 1'b1;
      end else if (sel && !controller_strobe) begin
         do_begin = 1'b1;
         do_access = 1'b1;
         do_write = wr_strobe;
         nxt_cyc = wr_strobe ? CYC_WRITE : CYC_READ;
      end else if (controller_strobe && (processor_strobe || chip_sel_low_a)) begin
         if (burst_open_ff) begin
            do_adv = !burst_advance_n;
            do_access = 1'b1;
            do_write = wr_strobe;
            nxt_cyc = wr_strobe ? CYC_WRITE : CYC_READ;
         end
      end else begin
         nxt_cyc = CYC_DESEL;
      end
   end

   // access address: external, next or current
   always_comb begin
      if (do_begin) begin
         acc_idx = addr[IDX_W-1:0];
      end else if (do_adv) begin
         acc_idx = {high_ff, burst_addr(seed_ff, BURST_W'(cnt_ff + 1'b1), mode_ff)};
      end else begin
         acc_idx = {high_ff, burst_addr(seed_ff, cnt_ff, mode_ff)};
      end
   end

   // burst counter
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         seed_ff <= '0;
         cnt_ff <= '0;
         high_ff <= '0;
         burst_open_ff <= 1'b0;
      end else if (nxt_cyc == CYC_SLEEP || nxt_cyc == CYC_DESEL) begin
         burst_open_ff <= 1'b0;
      end else if (do_begin) begin
         seed_ff <= addr[BURST_W-1:0];
         cnt_ff <= '0;
         high_ff <= addr[IDX_W-1:BURST_W];
         burst_open_ff <= 1'b1;
      end else if (do_adv) begin
         cnt_ff <= BURST_W'(cnt_ff + 1'b1);
      end
   end

   // read with forwarding of buffered writes
   always_comb begin
      fwd_word = mem[acc_idx];
      for (int i = 0; i < BUF_DEPTH; i++) begin
         if (ent_valid[i] && (ent_data[i][ENTRY_W-1 -: IDX_W] == acc_idx)) begin
            fwd_word = lane_merge(fwd_word, ent_data[i][DATA_W-1:0],
                                  ent_data[i][DATA_W +: LANES]);
         end
      end
   end

   // cycle type and read data register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         cyc_ff <= CYC_IDLE;
         rd_drive_ff <= 1'b0;
         dq_out_ff <= '0;
      end else begin
         cyc_ff <= nxt_cyc;
         rd_drive_ff <= do_access && !do_write;
         if (do_access && !do_write) begin
            dq_out_ff <= fwd_word;
         end
      end
   end

   // async output enable gates the drivers
   assign dq_out = dq_out_ff;
   assign dq_oe = rd_drive_ff && !output_enable_n && !sleep_request && !sleep_now;

   // write capture buffer
   pair_buffer #(
      .W(ENTRY_W),
      .DEPTH(BUF_DEPTH)
   ) u_wbuf (
      .mclk(mclk),
      .reset(reset),
      .in_valid(do_write),
      .in_ready(buf_in_ready),
      .in_data({acc_idx, lanes, dq_in}),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data),
      .ent_data(ent_data),
      .ent_valid(ent_valid)
   );

   assign wr_accept = buf_in_ready;
   assign drain_idx = buf_out_data[ENTRY_W-1 -: IDX_W];
   assign drain_lanes = buf_out_data[DATA_W +: LANES];
   assign drain_data = buf_out_data[DATA_W-1:0];
   assign buf_out_ready = !sw_mem_wr && !ctrl_ff[CTRL_HOLD_BIT];

   // storage array
   always_ff @(posedge mclk) begin
      if (sw_mem_wr) begin
         mem[mem_addr_ff] <= {dhi_ff, avs_writedata};
      end else if (buf_out_valid && buf_out_ready) begin
         mem[drain_idx] <= lane_merge(mem[drain_idx], drain_data, drain_lanes);
      end
   end

   // avalon slave: one wait cycle per access
   assign av_req = avs_read || avs_write;
   assign avs_waitrequest = av_req && !ack_ff;
   assign av_acc = av_req && ack_ff;
   assign sw_mem_wr = av_acc && avs_write && (avs_address == REG_MEM_DLO);
   assign avs_readdata = rdata_ff;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= av_req && !ack_ff;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata_ff <= '0;
      end else if (avs_read && !ack_ff) begin
         rdata_ff <= '0;
         case (avs_address)
            REG_CTRL: begin
               rdata_ff[CTRL_W-1:0] <= ctrl_ff;
            end
            REG_STATUS: begin
               rdata_ff[ST_CYC_LSB +: $bits(cyc_t)] <= cyc_ff;
               rdata_ff[ST_BURST_LSB +: BURST_W] <= burst_addr(seed_ff, cnt_ff, mode_ff);
               rdata_ff[ST_SLEEP_BIT] <= sleep_now;
               rdata_ff[ST_FULL_BIT] <= !buf_in_ready;
            end
            REG_MEM_ADDR: begin
               rdata_ff[IDX_W-1:0] <= mem_addr_ff;
            end
            REG_MEM_DLO: begin
               rdata_ff <= mem[mem_addr_ff][AV_DATA_W-1:0];
            end
            REG_MEM_DHI: begin
               rdata_ff[HI_W-1:0] <= mem[mem_addr_ff][DATA_W-1:AV_DATA_W];
            end
            default: begin
               rdata_ff <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= CTRL_RST;
         mem_addr_ff <= '0;
         dhi_ff <= '0;
      end else if (av_acc && avs_write) begin
         case (avs_address)
            REG_CTRL: begin
               ctrl_ff <= avs_writedata[CTRL_W-1:0];
            end
            REG_MEM_ADDR: begin
               mem_addr_ff <= avs_writedata[IDX_W-1:0];
            end
            REG_MEM_DHI: begin
               dhi_ff <= avs_writedata[HI_W-1:0];
            end
            default: begin
               ctrl_ff <= ctrl_ff;
            end
         endcase
      end
   end
endmodule : sram_cycle_decode

/* sram_cycle_decode_sva.sv */
// Purpose: port checker for the cycle decode
// Assumes: sleep reaches the decode two edges late
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module sram_cycle_decode_sva (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // memory pins
   input wire logic chip_sel_low_a,
   input wire logic chip_sel_high,
   input wire logic chip_sel_low_b,
   input wire logic processor_strobe,
   input wire logic controller_strobe,
   input wire logic global_write_n,
   input wire logic byte_write_gate_n,
   input wire logic [sram_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic dq_oe
);
   import sram_pkg::*;
   wire logic sel = !chip_sel_low_a && chip_sel_high && !chip_sel_low_b;
   wire logic wr = !global_write_n || (!byte_write_gate_n && byte_lane_write_n != 4'hF);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   sequence s_awake;
      !sleep_request [*4];
   endsequence
   property p_sleep_off;
      sleep_request |-> !dq_oe;
   endproperty
   a_sleep_off: assert property (p_sleep_off)
      else $error("data driven in sleep");
   property p_oe_off;
      output_enable_n |-> !dq_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("data driven with output enable high");
   property p_desel_a;
      chip_sel_low_a && !controller_strobe |=> !dq_oe;
   endproperty
   a_desel_a: assert property (p_desel_a)
      else $error("data driven after deselect");
   property p_desel_b;
      !chip_sel_low_a && (!chip_sel_high || chip_sel_low_b)
         && !(processor_strobe && controller_strobe) |=> !dq_oe;
   endproperty
   a_desel_b: assert property (p_desel_b)
      else $error("data driven after deselect");
   property p_rd_begin;
      s_awake ##0 (sel && !processor_strobe) ##1 (!output_enable_n && !sleep_request)
         |-> dq_oe;
   endproperty
   a_rd_begin: assert property (p_rd_begin)
      else $error("read begin not driven");
   property p_rd_ctrl;
      s_awake ##0 (sel && processor_strobe && !controller_strobe && !wr)
         ##1 (!output_enable_n && !sleep_request) |-> dq_oe;
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl)
      else $error("controller read not driven");
   property p_wr_mask;
      sel && processor_strobe && !controller_strobe && wr |=> !dq_oe;
   endproperty
   a_wr_mask: assert property (p_wr_mask)
      else $error("data driven in write");
   property p_burst_rd;
      s_awake ##0 (sel && !processor_strobe) ##1 (processor_strobe && controller_strobe && !wr)
         ##1 (!output_enable_n && !sleep_request) |-> dq_oe;
   endproperty
   a_burst_rd: assert property (p_burst_rd)
      else $error("burst read not driven");
   c_rd: cover property (sel && !processor_strobe);
   c_wr: cover property (sel && processor_strobe && !controller_strobe && wr);
   c_sleep: cover property (sleep_request);
endmodule : sram_cycle_decode_sva
bind sram_cycle_decode sram_cycle_decode_sva i_sva (.mclk, .reset, .chip_sel_low_a,
   .chip_sel_high, .chip_sel_low_b, .processor_strobe, .controller_strobe, .global_write_n,
   .byte_write_gate_n, .byte_lane_write_n, .output_enable_n, .sleep_request, .dq_oe);

/* host_pins.sv */
// Purpose: processor side model driving the synchronous pins
// Assumes: one call per clock, pins change just after the edge
// Notes: released data bus shows the inverse of its last value
`timescale 1ns/1ps
module host_pins (
   // clock
   input wire logic mclk,
   // pins toward the memory
   output logic [sram_pkg::ADDR_W-1:0] addr,
   output logic chip_sel_low_a,
   output logic chip_sel_high,
   output logic chip_sel_low_b,
   output logic processor_strobe,
   output logic controller_strobe,
   output logic burst_advance_n,
   output logic global_write_n,
   output logic byte_write_gate_n,
   output logic [sram_pkg::LANES-1:0] byte_lane_write_n,
   output logic [sram_pkg::DATA_W-1:0] dq_in,
   output logic output_enable_n
);
   import sram_pkg::*;
   initial begin
      {chip_sel_low_a, chip_sel_high, chip_sel_low_b} = 3'h4;
      {processor_strobe, controller_strobe, burst_advance_n, output_enable_n} = 4'hF;
      {global_write_n, byte_write_gate_n, byte_lane_write_n} = 6'h3F;
      addr = '0;
      dq_in = '0;
   end
   // m: 0 selected, 1 low select off, 2 high select off
   task cyc(input logic [1:0] m, input logic [2:0] pca, input logic [5:0] w,
            input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      logic wr;
      wr = !w[5] || (!w[4] && w[3:0] != 4'hF);
      @(posedge mclk);
      chip_sel_low_a <= (m == 2'd1);
      chip_sel_high <= (m != 2'd2);
      chip_sel_low_b <= 1'b0;
      {processor_strobe, controller_strobe, burst_advance_n} <= pca;
      {global_write_n, byte_write_gate_n, byte_lane_write_n} <= w;
      addr <= a;
      output_enable_n <= wr;
      dq_in <= wr ? d : ~dq_in;
   endtask : cyc
   // deselect, closes any open burst
   task idle();
      cyc(2'd1, 3'b101, 6'h3F, '0, '0);
   endtask : idle
endmodule : host_pins

/* sram_cycle_decode_test.sv */
// Purpose: self-checking bench for the burst memory cycle decode
// Assumes: 125 MHz clock, reset held three cycles
// Notes: array set up and read back over the register bus
`timescale 1ns/1ps
module sram_cycle_decode_test;
   import sram_pkg::*;
   localparam logic [DATA_W-1:0] WD = 36'h9_8765_4321;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic sleep_request = 1'b0;
   logic mode_linear = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [AV_ADDR_W-1:0] avs_address = '0;
   logic [AV_DATA_W-1:0] avs_writedata = '0;
   logic [AV_DATA_W-1:0] avs_readdata, rd;
   logic [ADDR_W-1:0] addr;
   logic chip_sel_low_a, chip_sel_high, chip_sel_low_b, processor_strobe;
   logic controller_strobe, burst_advance_n, global_write_n, byte_write_gate_n;
   logic output_enable_n, dq_oe, wr_accept, avs_waitrequest;
   logic [LANES-1:0] byte_lane_write_n;
   logic [DATA_W-1:0] dq_in, dq_out, v, d;
   int n_errors = 0;
   int checks = 0;
   int c;
   always #4 mclk = ~mclk;
   host_pins i_host (.mclk, .addr, .chip_sel_low_a, .chip_sel_high, .chip_sel_low_b,
      .processor_strobe, .controller_strobe, .burst_advance_n, .global_write_n,
      .byte_write_gate_n, .byte_lane_write_n, .dq_in, .output_enable_n);
   sram_cycle_decode i_dut (.mclk, .reset, .addr, .chip_sel_low_a, .chip_sel_high,
      .chip_sel_low_b, .processor_strobe, .controller_strobe, .burst_advance_n,
      .global_write_n, .byte_write_gate_n, .byte_lane_write_n, .dq_in, .output_enable_n,
      .sleep_request, .mode_linear, .dq_out, .dq_oe, .wr_accept, .avs_address, .avs_read,
      .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
   task print_verdict();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task chk(input string s, input logic [DATA_W-1:0] e, v);
      checks++;
      if (v !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   // one avalon transfer, held until waitrequest is seen low
   task av(input logic w, input logic [AV_ADDR_W-1:0] a, input logic [AV_DATA_W-1:0] wd);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= wd;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         $display("[ERR] waitrequest expected 0 seen %b", avs_waitrequest);
         print_verdict();
      end
   endtask : av
   task mw(input int i, input logic [DATA_W-1:0] x);
      av(1'b1, REG_MEM_ADDR, 32'(i));
      av(1'b1, REG_MEM_DHI, 32'(x[35:32]));
      av(1'b1, REG_MEM_DLO, x[31:0]);
   endtask : mw
   task mr(input int i);
      av(1'b1, REG_MEM_ADDR, 32'(i));
      av(1'b0, REG_MEM_DHI, '0);
      v[35:32] = rd[3:0];
      av(1'b0, REG_MEM_DLO, '0);
      v[31:0] = rd;
   endtask : mr
   function automatic logic [DATA_W-1:0] pat(input int i);
      pat = {i[3:0], 32'hC0DE_0000 | 32'(i)};
   endfunction : pat
   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      $display("[ERR] run expected done seen timeout");
      print_verdict();
   end
   initial begin
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      av(1'b0, REG_CTRL, '0);
      chk("ctrl", CTRL_RST, rd);
      av(1'b1, REG_CTRL, 32'h2);
      av(1'b1, 5'h14, 32'hFFFF_FFFF);
      av(1'b0, REG_CTRL, '0);
      chk("ctrl", 2'h2, rd);
      av(1'b0, 5'h14, '0);
      chk("unmapped", '0, rd);
      av(1'b1, REG_CTRL, '0);
      for (int i = 0; i < MEM_WORDS; i++) mw(i, pat(i));
      $display("test registers done");
      for (int m = 1; m >= 0; m--) begin
         mode_linear <= m[0];
         repeat (3) i_host.idle();
         i_host.cyc(2'd0, 3'b011, 6'h3F, 19'h5, '0);
         for (int k = 0; k < 5; k++) begin
            if (k < 4) i_host.cyc(2'd0, {2'b11, k == 1}, 6'h3F, '0, '0);
            else i_host.idle();
            #1;
            c = k - (k > 1);
            chk("dq_out", pat(4 + (m ? (1 + c) % 4 : 1 ^ c)), dq_out);
            chk("dq_oe", 1'b1, dq_oe);
         end
      end
      av(1'b0, REG_STATUS, '0);
      chk("burst", 2'h2, rd[ST_BURST_LSB +: BURST_W]);
      $display("test bursts done");
      i_host.cyc(2'd0, 3'b101, 6'h2A, 19'h8, WD);
      i_host.cyc(2'd0, 3'b101, 6'h1F, 19'h9, WD);
      i_host.cyc(2'd0, 3'b011, 6'h00, 19'hA, WD);
      i_host.cyc(2'd0, 3'b101, 6'h2F, 19'hB, WD);
      repeat (2) i_host.idle();
      d = pat(8);
      mr(8);
      chk("word8", {d[35:27], WD[26:18], d[17:9], WD[8:0]}, v);
      mr(9);
      chk("word9", WD, v);
      for (int i = 10; i < 12; i++) begin
         mr(i);
         chk("word", pat(i), v);
      end
      $display("test writes done");
      av(1'b1, REG_CTRL, 32'h2);
      for (int i = 12; i < 15; i++) i_host.cyc(2'd0, 3'b101, 6'h1F, 19'(i), ~pat(i));
      #1;
      chk("wr_accept", 1'b0, wr_accept);
      i_host.idle();
      av(1'b0, REG_STATUS, '0);
      chk("full", 1'b1, rd[ST_FULL_BIT]);
      av(1'b1, REG_CTRL, '0);
      repeat (3) i_host.idle();
      #1;
      chk("wr_accept", 1'b1, wr_accept);
      for (int i = 12; i < 15; i++) begin
         mr(i);
         chk("word", i < 14 ? ~pat(i) : pat(i), v);
      end
      $display("test buffer done");
      sleep_request <= 1'b1;
      i_host.cyc(2'd0, 3'b011, 6'h3F, 19'h1, '0);
      #1;
      chk("dq_oe", 1'b0, dq_oe);
      repeat (2) i_host.idle();
      av(1'b0, REG_STATUS, '0);
      chk("status", 4'hC, {rd[ST_SLEEP_BIT], rd[2:0]});
      sleep_request <= 1'b0;
      repeat (4) i_host.idle();
      i_host.cyc(2'd2, 3'b011, 6'h3F, '0, '0);
      av(1'b0, REG_STATUS, '0);
      chk("cycle", 3'h1, rd[2:0]);
      av(1'b1, REG_CTRL, 32'h1);
      av(1'b0, REG_STATUS, '0);
      chk("forced sleep", 4'hC, {rd[ST_SLEEP_BIT], rd[2:0]});
      av(1'b1, REG_CTRL, '0);
      $display("test sleep done");
      print_verdict();
   end
endmodule : sram_cycle_decode_test
